// ### rtl/nv_store_ctrl.sv
// controller for the 512-byte nonvolatile data store on the i/o bus
// assumes cpu honours stall_cpu and holds its next instruction
`timescale 1ns/1ns
module nv_store_ctrl
    import nv_store_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // i/o register port
    input wire logic [1:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // cpu hold and ready request
    output logic stall_cpu,
    output logic ready_irq
);
    nv_array_if arr ();

    nv_array u_array (
        .clock(clock),
        .port(arr.array)
    );

    logic [8:0] nv_byte_address;
    logic [7:0] nv_data_byte;
    logic [1:0] prog_mode;
    logic ready_irq_en;
    logic master_write_arm;
    logic write_strobe;
    logic [2:0] arm_count;
    logic [PROG_CNT_W-1:0] prog_count;
    logic [STALL_CNT_W-1:0] stall_count;
    logic busy;
    logic ctl_wr;
    logic start_write;
    logic start_read;
    logic [7:0] control_view;

    function automatic logic [PROG_CNT_W-1:0] prog_len(
        input logic [1:0] mode
    );
        if (mode == MODE_ATOMIC) begin
            return PROG_CNT_W'(ATOMIC_CYCLES);
        end
        return PROG_CNT_W'(SPLIT_CYCLES);
    endfunction : prog_len

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign busy = write_strobe;
    assign ctl_wr = io_write && io_addr == REG_CONTROL;
    assign start_write = ctl_wr && io_wdata[BIT_WRITE_STROBE]
        && master_write_arm && !busy;
    // read refused during a write cycle
    assign start_read = ctl_wr && io_wdata[BIT_READ_STROBE] && !busy;

    // ------------------------------------------------------------
    // address and data
    // ------------------------------------------------------------
    // address split high/low; frozen while busy
    always_ff @(posedge clock) begin
        if (io_write && !busy && io_addr == REG_ADDR_LOW) begin
            nv_byte_address[7:0] <= io_wdata;
        end
        if (io_write && !busy && io_addr == REG_ADDR_HIGH) begin
            nv_byte_address[8] <= io_wdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nv_data_byte <= DATA_RESET;
        end else if (start_read) begin
            nv_data_byte <= arr.rdata;
        end else if (io_write && io_addr == REG_DATA) begin
            nv_data_byte <= io_wdata;
        end
    end

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    // mode kept through reset while programming
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            if (!busy) begin
                prog_mode <= MODE_ATOMIC;
            end
        end else if (ctl_wr && !busy && !start_write) begin
            prog_mode <= io_wdata[BIT_MODE_HI:BIT_MODE_LO];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_irq_en <= 1'b0;
        end else if (ctl_wr) begin
            ready_irq_en <= io_wdata[BIT_READY_IRQ_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            master_write_arm <= 1'b0;
            arm_count <= 3'h0;
        end else if (ctl_wr && io_wdata[BIT_WRITE_ARM]) begin
            master_write_arm <= 1'b1;
            arm_count <= 3'(ARM_CYCLES - 1);
        end else if (arm_count != 3'h0) begin
            arm_count <= arm_count - 3'h1;
        end else begin
            master_write_arm <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // self-timed programming
    // ------------------------------------------------------------
    // a reset mid-cycle lets the cycle finish, as cells expect
    // strobe reads busy; timed length
    always_ff @(posedge clock) begin
        if (start_write && rst_n) begin
            write_strobe <= 1'b1;
            prog_count <= prog_len(prog_mode);
        // strobe drops at end of interval
        end else if (busy && prog_count == PROG_CNT_W'(1)) begin
            write_strobe <= 1'b0;
            prog_count <= '0;
        end else if (busy) begin
            prog_count <= prog_count - PROG_CNT_W'(1);
        end else if (!rst_n) begin
            write_strobe <= 1'b0;
            prog_count <= '0;
        end
    end

    // store at end; mode picks value
    assign arr.addr = nv_byte_address;
    assign arr.write = busy && prog_count == PROG_CNT_W'(1)
        && prog_mode != MODE_RESERVED;
    assign arr.wdata = prog_mode == MODE_ERASE ? ERASED_BYTE
        : prog_mode == MODE_WRITE ? (arr.rdata & nv_data_byte)
        : nv_data_byte;

    // ------------------------------------------------------------
    // cpu stall
    // ------------------------------------------------------------
    // four-cycle read hold; two-cycle write hold
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stall_count <= '0;
        end else if (start_read) begin
            stall_count <= STALL_CNT_W'(READ_STALL);
        end else if (start_write) begin
            stall_count <= STALL_CNT_W'(WRITE_STALL);
        end else if (stall_count != '0) begin
            stall_count <= stall_count - STALL_CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stall_cpu <= 1'b0;
        end else begin
            stall_cpu <= start_read || start_write
                || stall_count > STALL_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // readback and ready request
    // ------------------------------------------------------------
    // reserved bits read zero
    assign control_view = {2'h0, prog_mode, ready_irq_en,
        master_write_arm, write_strobe, 1'b0};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else if (io_read) begin
            unique case (io_addr)
                REG_CONTROL: io_rdata <= control_view;
                REG_DATA: io_rdata <= nv_data_byte;
                REG_ADDR_LOW: io_rdata <= nv_byte_address[7:0];
                REG_ADDR_HIGH: io_rdata <= {7'h00, nv_byte_address[8]};
            endcase
        end
    end

    // level request while idle and enabled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_irq <= 1'b0;
        end else begin
            ready_irq <= ready_irq_en && !busy;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_unarmed_no_write;
        @(posedge clock) disable iff (!rst_n)
        (ctl_wr && io_wdata[BIT_WRITE_STROBE] && !master_write_arm
            && !busy) |=> !write_strobe;
    endproperty
    a_unarmed_no_write: assert property (p_unarmed_no_write)
        else $error("write started without arm");
    property p_read_stall;
        @(posedge clock) disable iff (!rst_n)
        start_read |=> stall_cpu [*4] ##1 !stall_cpu;
    endproperty
    a_read_stall: assert property (p_read_stall)
        else $error("read stall not four cycles");
    property p_write_stall;
        @(posedge clock) disable iff (!rst_n)
        start_write |=> stall_cpu [*2] ##1 !stall_cpu;
    endproperty
    a_write_stall: assert property (p_write_stall)
        else $error("write stall not two cycles");
    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        $past(io_read) && $past(io_addr) != REG_DATA
            && $past(io_addr) != REG_ADDR_LOW |-> io_rdata[7:6] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");
    property p_read_data;
        @(posedge clock) disable iff (!rst_n)
        start_read |=> nv_data_byte == $past(arr.rdata);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data not loaded");
    property p_mode_locked;
        @(posedge clock) disable iff (!rst_n)
        busy && $past(busy) |-> $stable(prog_mode);
    endproperty
    a_mode_locked: assert property (p_mode_locked)
        else $error("mode changed while busy");
    property p_reserved_no_store;
        @(posedge clock) disable iff (!rst_n)
        prog_mode == MODE_RESERVED |-> !arr.write;
    endproperty
    a_reserved_no_store: assert property (p_reserved_no_store)
        else $error("reserved mode wrote cells");
    property p_arm_clears;
        @(posedge clock) disable iff (!rst_n)
        ctl_wr && io_wdata[BIT_WRITE_ARM] ##1 !ctl_wr [*4]
            |=> !master_write_arm;
    endproperty
    a_arm_clears: assert property (p_arm_clears)
        else $error("arm did not clear");
    property p_ready_level;
        @(posedge clock) disable iff (!rst_n)
        ##1 1'b1 |-> ready_irq == $past(ready_irq_en && !busy);
    endproperty
    a_ready_level: assert property (p_ready_level)
        else $error("ready request wrong");

    c_write: cover property (@(posedge clock) disable iff (!rst_n)
        start_write);
    c_read: cover property (@(posedge clock) disable iff (!rst_n) start_read);
    c_done: cover property (@(posedge clock) disable iff (!rst_n) arr.write);
endmodule : nv_store_ctrl

// ### rtl/nv_store_pkg.sv
// constants for the byte-wide nonvolatile data store controller
// assumes a 100 MHz cpu clock and an 8-bit i/o register port
package nv_store_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int STORE_BYTES = 512;
    localparam int ADDR_W = 9;
    // ------------------------------------------------------------
    // i/o register indices
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CONTROL = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_ADDR_LOW = 2'h2;
    localparam logic [1:0] REG_ADDR_HIGH = 2'h3;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_WRITE_ARM = 2;
    localparam int BIT_READY_IRQ_EN = 3;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_MODE_HI = 5;
    // ------------------------------------------------------------
    // modes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_ATOMIC = 2'h0;
    localparam logic [1:0] MODE_ERASE = 2'h1;
    localparam logic [1:0] MODE_WRITE = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 100;
    localparam int ATOMIC_TIME_US = 3400;
    localparam int SPLIT_TIME_US = 1800;
    localparam int ATOMIC_CYCLES = ATOMIC_TIME_US * CLOCK_MHZ;
    localparam int SPLIT_CYCLES = SPLIT_TIME_US * CLOCK_MHZ;
    localparam int ARM_CYCLES = 4;
    localparam int READ_STALL = 4;
    localparam int WRITE_STALL = 2;
    localparam int PROG_CNT_W = 20;
    localparam int STALL_CNT_W = 3;
endpackage : nv_store_pkg

// ### rtl/nv_array_if.sv
// carrier between controller and storage array
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface nv_array_if;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic write;
    logic [7:0] rdata;
    modport ctrl (output addr, output wdata, output write, input rdata);
    modport array (input addr, input wdata, input write, output rdata);
endinterface : nv_array_if

// ### rtl/nv_array.sv
// byte storage array for the nonvolatile data store
// assumes writes come from the controller only when a cycle finishes
`timescale 1ns/1ns
module nv_array
    import nv_store_pkg::*;
(
    // clock
    input wire logic clock,
    // array side
    nv_array_if.array port
);
    // 512 bytes, shipped erased
    // known start value keeps a first read from returning unknowns
    logic [7:0] cells [STORE_BYTES] = '{default: ERASED_BYTE};

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: contents survive reset like real nonvolatile cells
    always_ff @(posedge clock) begin
        if (port.write) begin
            cells[port.addr] <= port.wdata;
        end
    end

    assign port.rdata = cells[port.addr];
endmodule : nv_array

// ### sim/eeprom_data_access_ctrl_bench.sv
// self-checking bench for the nonvolatile data store controller
// assumes the controller top instantiates its own storage array
`timescale 1ns/1ns
module eeprom_data_access_ctrl_bench;
    import nv_store_pkg::*;
    // ------------------------------------------------------------
    // ports and counters
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] io_addr = 2'h0;
    logic io_write = 1'b0;
    logic io_read = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic stall_cpu;
    logic ready_irq;
    int bad_count = 0;
    int check_count = 0;
    logic [7:0] v, lo, hi;
    int n;

    nv_store_ctrl dut (
        .clock(clock),
        .rst_n(rst_n),
        .io_addr(io_addr),
        .io_write(io_write),
        .io_read(io_read),
        .io_wdata(io_wdata),
        .io_rdata(io_rdata),
        .stall_cpu(stall_cpu),
        .ready_irq(ready_irq)
    );

    initial begin
        forever #5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input string what, input logic [7:0] seen,
               input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // write strobe stays up across back-to-back writes
    task wr(input logic [1:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_read <= 1'b0;
        io_write <= 1'b1;
        @(posedge clock);
    endtask : wr

    task rd(input logic [1:0] a, output logic [7:0] d);
        io_addr <= a;
        io_write <= 1'b0;
        io_read <= 1'b1;
        @(posedge clock);
        io_read <= 1'b0;
        @(negedge clock);
        d = io_rdata;
        @(posedge clock);
    endtask : rd

    // count stall cycles over a window started at the taken edge
    task count_stall(output int c);
        c = 0;
        io_write <= 1'b0;
        repeat (10) begin
            @(negedge clock);
            if (stall_cpu === 1'b1) c++;
        end
        @(posedge clock);
    endtask : count_stall

    task do_reset;
        @(posedge clock);
        io_write <= 1'b0;
        io_read <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset

    function automatic logic [7:0] exp_high(input logic [7:0] w);
        return {7'h00, w[0]};
    endfunction : exp_high

    function automatic logic [7:0] mode_bits(input logic [7:0] c);
        return c & 8'h30;
    endfunction : mode_bits
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(12403));
        do_reset();
        rd(REG_DATA, v);
        check("data reset", v, DATA_RESET);
        rd(REG_CONTROL, v);
        check("control reset", v, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(REG_CONTROL, 8'(m << BIT_MODE_LO));
            rd(REG_CONTROL, v);
            check("mode", mode_bits(v), 8'(m << 4));
        end
        wr(REG_CONTROL, 8'hE0);
        rd(REG_CONTROL, v);
        check("control top bits", v, 8'h20);
        do_reset();
        rd(REG_CONTROL, v);
        check("mode after idle reset", mode_bits(v), 8'h00);
        for (int i = 0; i < 10; i++) begin
            lo = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            hi = (i == 1) ? 8'hFF : 8'($urandom);
            wr(REG_ADDR_LOW, lo);
            wr(REG_ADDR_HIGH, hi);
            wr(REG_DATA, ~lo);
            rd(REG_ADDR_LOW, v);
            check("addr low", v, lo);
            rd(REG_ADDR_HIGH, v);
            check("addr high", v, exp_high(hi));
            rd(REG_DATA, v);
            check("data", v, ~lo);
        end
        wr(REG_CONTROL, 8'h01);
        count_stall(n);
        check("read stall", 8'(n), 8'(READ_STALL));
        rd(REG_DATA, v);
        check("read erased", v, ERASED_BYTE);
        rd(REG_CONTROL, v);
        check("read strobe back", v, 8'h00);
        wr(REG_CONTROL, 8'h08);
        count_stall(n);
        check("ready idle", {7'h00, ready_irq}, 8'h01);
        wr(REG_CONTROL, 8'h0A);
        count_stall(n);
        check("unarmed stall", 8'(n), 8'h00);
        rd(REG_CONTROL, v);
        check("unarmed strobe", v, 8'h08);
        // strobe after arm window is refused
        wr(REG_CONTROL, 8'h0C);
        io_write <= 1'b0;
        repeat (6) @(posedge clock);
        rd(REG_CONTROL, v);
        check("arm cleared", v, 8'h08);
        wr(REG_CONTROL, 8'h0A);
        count_stall(n);
        check("late stall", 8'(n), 8'h00);
        rd(REG_CONTROL, v);
        check("late strobe", v, 8'h08);
        // address loaded before the armed erase
        wr(REG_ADDR_LOW, 8'h5A);
        wr(REG_ADDR_HIGH, 8'h01);
        wr(REG_CONTROL, 8'h1C);
        wr(REG_CONTROL, 8'h1A);
        count_stall(n);
        check("write stall", 8'(n), 8'(WRITE_STALL));
        rd(REG_CONTROL, v);
        check("busy control", v, 8'h1A);
        check("ready busy", {7'h00, ready_irq}, 8'h00);
        wr(REG_CONTROL, 8'h2A);
        rd(REG_CONTROL, v);
        check("mode locked", mode_bits(v), 8'h10);
        wr(REG_ADDR_LOW, 8'hA5);
        rd(REG_ADDR_LOW, v);
        check("addr locked", v, 8'h5A);
        wr(REG_CONTROL, 8'h19);
        count_stall(n);
        check("read refused", 8'(n), 8'h00);
        do_reset();
        rd(REG_CONTROL, v);
        check("mode kept busy", mode_bits(v), 8'h10);
        check("strobe kept", v & 8'hC2, 8'h02);
        tally_and_finish();
    end
endmodule : eeprom_data_access_ctrl_bench
